// file: logic/rtbx_core.sv
// execution of transfer, ram pointer and branch instructions
// assumes one instruction per clock, ram read data combinational for the current pointer
//
// Functional notes
// - 0x01e copies b to acc; companion 0x00e copies acc to b
// - 0x01f copies row pointer y into acc
// - 0x01a writes b to e high nibble, acc to e low
// - 0x02a loads b from e high, acc from e low
// - 0x029 copies acc bits 2..0 into jump-high register d
// - reading d gives acc bits 2..0 from d, bit 3 zero
// - 0x053 puts file select z into acc low bits, upper zero
// - 0x050 puts stack pointer into acc low bits, bit 3 zero
// - immediate pointer load sets x and y from fields
// - consecutive pointer loads after the first are skipped
// - file load writes 2-bit immediate into z
// - increment y, skip next when result is zero
// - decrement y, skip next when result is fifteen
// - 0x2cj loads acc from ram, then x ^= j
// - 0x2dj swaps acc with ram, then x ^= j
// - 0x2fj swap, x ^= j, decrement y, skip on fifteen
// - 0x2ej swap, x ^= j, increment y, skip on zero
// - 0x2bj stores acc to ram, then x ^= j
// - branch targets current page or page p
// - indirect branch address is d above acc in page p
// - calls target page 2 or any page p, flagged on o_call
// - indirect call address is d above acc in page p
`timescale 1ns/1ps
module rtbx_core
  import rtbx_pkg::*;
#(
  parameter int PAGE_W = 6
)
(
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_valid,
  input wire logic [9:0] i_instr,
  input wire rtbx_br_t i_br_kind,
  input wire logic [5:0] i_br_page,
  input wire logic [6:0] i_br_addr,
  input wire logic [5:0] i_cur_page,
  input wire logic [2:0] i_stack_ptr,
  input wire logic [3:0] i_ram_rdata,
  output logic [3:0] o_acc,
  output logic [3:0] o_breg,
  output logic [3:0] o_xreg,
  output logic [3:0] o_yreg,
  output logic [1:0] o_zreg,
  output logic [2:0] o_dreg,
  output logic [7:0] o_ereg,
  output logic o_skip,
  output logic o_ram_we,
  output logic [3:0] o_ram_wdata,
  output logic o_jump,
  output logic o_call,
  output logic [12:0] o_target
);

  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    logic [3:0] acc;
    logic [3:0] breg;
    logic [3:0] xreg;
    logic [3:0] yreg;
    logic [1:0] zreg;
    logic [2:0] dreg;
    logic [7:0] ereg;
    logic skip;
    logic last_lxy;
    logic ram_we;
    logic [3:0] ram_wdata;
    logic jump;
    logic call;
    logic [12:0] target;
  } rtbx_state_t;

  rtbx_state_t st;
  rtbx_state_t next_st;
  logic [12:0] tgt;
  logic tgt_take;
  logic tgt_call;
  logic is_lxy;
  logic [3:0] j_imm;
  logic [5:0] op_hi;

  rtbx_target u_target
  (
    .i_kind(i_br_kind),
    .i_cur_page(i_cur_page),
    .i_page(i_br_page),
    .i_addr(i_br_addr),
    .i_dreg(st.dreg),
    .i_acc(st.acc),
    .o_target(tgt),
    .o_take(tgt_take),
    .o_call(tgt_call)
  );

  assign is_lxy = (i_instr[9:8] == RTBX_OP_LXY_HI[1:0]);
  assign j_imm = i_instr[3:0];
  assign op_hi = i_instr[9:4];

  ////////////////////////////////////////////////////////////////////////////
  // execute
  always_comb
  begin
    next_st = st;
    // pending skip waits for the next valid instruction
    next_st.skip = st.skip && !i_valid;
    next_st.ram_we = 1'b0;
    next_st.jump = 1'b0;
    next_st.call = 1'b0;
    if (i_valid)
    begin
      next_st.last_lxy = is_lxy;
      if (st.skip || (is_lxy && st.last_lxy))
      begin
        next_st.skip = 1'b0;
      end
      else if (i_br_kind != RTBX_BR_NONE)
      begin
        next_st.jump = tgt_take;
        next_st.call = tgt_call;
        next_st.target = tgt;
      end
      else if (is_lxy)
      begin
        next_st.xreg = i_instr[7:4];
        next_st.yreg = i_instr[3:0];
      end
      else
      begin
        case (op_hi)
          RTBX_OP_TAM_HI:
          begin
            next_st.acc = i_ram_rdata;
            next_st.xreg = st.xreg ^ j_imm;
          end
          RTBX_OP_XAM_HI, RTBX_OP_SWAP_DEC_SKIP_HI, RTBX_OP_SWAP_INC_SKIP_HI:
          begin
            next_st.acc = i_ram_rdata;
            next_st.ram_we = 1'b1;
            next_st.ram_wdata = st.acc;
            next_st.xreg = st.xreg ^ j_imm;
            if (op_hi == RTBX_OP_SWAP_DEC_SKIP_HI)
            begin
              next_st.yreg = st.yreg - 4'h1;
              next_st.skip = (next_st.yreg == RTBX_Y_MAX);
            end
            if (op_hi == RTBX_OP_SWAP_INC_SKIP_HI)
            begin
              next_st.yreg = st.yreg + 4'h1;
              next_st.skip = (next_st.yreg == RTBX_Y_MIN);
            end
          end
          RTBX_OP_TMA_HI:
          begin
            next_st.ram_we = 1'b1;
            next_st.ram_wdata = st.acc;
            next_st.xreg = st.xreg ^ j_imm;
          end
          default:
          begin
            if (i_instr[9:2] == RTBX_OP_LZ_HI)
            begin
              next_st.zreg = i_instr[1:0];
            end
            case (i_instr)
              RTBX_OP_TAB: next_st.acc = st.breg;
              RTBX_OP_TBA: next_st.breg = st.acc;
              RTBX_OP_TAY: next_st.acc = st.yreg;
              RTBX_OP_TYA: next_st.yreg = st.acc;
              RTBX_OP_WRITE_WIDE_REG: next_st.ereg = {st.breg, st.acc};
              RTBX_OP_READ_WIDE_REG:
              begin
                next_st.breg = st.ereg[7:4];
                next_st.acc = st.ereg[3:0];
              end
              RTBX_OP_TDA: next_st.dreg = st.acc[2:0];
              RTBX_OP_TAD: next_st.acc = {1'b0, st.dreg};
              RTBX_OP_TAZ: next_st.acc = {2'b00, st.zreg};
              RTBX_OP_TAX: next_st.acc = st.xreg;
              RTBX_OP_READ_STACK_PTR: next_st.acc = {1'b0, i_stack_ptr};
              RTBX_OP_INY:
              begin
                next_st.yreg = st.yreg + 4'h1;
                next_st.skip = (st.yreg == RTBX_Y_MAX);
              end
              RTBX_OP_DEY:
              begin
                next_st.yreg = st.yreg - 4'h1;
                next_st.skip = (st.yreg == RTBX_Y_MIN);
              end
              default: next_st.skip = 1'b0;
            endcase
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign o_acc = st.acc;
  assign o_breg = st.breg;
  assign o_xreg = st.xreg;
  assign o_yreg = st.yreg;
  assign o_zreg = st.zreg;
  assign o_dreg = st.dreg;
  assign o_ereg = st.ereg;
  assign o_skip = st.skip;
  assign o_ram_we = st.ram_we;
  assign o_ram_wdata = st.ram_wdata;
  assign o_jump = st.jump;
  assign o_call = st.call;
  assign o_target = st.target;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  logic exec;
  assign exec = i_valid && !st.skip && !(is_lxy && st.last_lxy) && (i_br_kind == RTBX_BR_NONE);

  AST_TAB: assert property (@(posedge i_clk) disable iff (i_srst)
    exec && i_instr == RTBX_OP_TAB |=> o_acc == $past(o_breg))
    else $error("acc not loaded from b");
  AST_TAY: assert property (@(posedge i_clk) disable iff (i_srst)
    exec && i_instr == RTBX_OP_TAY |=> o_acc == $past(o_yreg))
    else $error("acc not loaded from y");
  AST_WRITE_WIDE_REG: assert property (@(posedge i_clk) disable iff (i_srst)
    exec && i_instr == RTBX_OP_WRITE_WIDE_REG |=> o_ereg == {$past(o_breg), $past(o_acc)})
    else $error("e not written from b and acc");
  AST_TAD: assert property (@(posedge i_clk) disable iff (i_srst)
    exec && i_instr == RTBX_OP_TAD |=> o_acc[3] == 1'b0 && o_acc[2:0] == $past(o_dreg))
    else $error("d readback wrong");
  AST_LXY2: assert property (@(posedge i_clk) disable iff (i_srst)
    i_valid && is_lxy && st.last_lxy && !st.skip |=> $stable(o_xreg) && $stable(o_yreg))
    else $error("consecutive pointer load executed");
  AST_INY: assert property (@(posedge i_clk) disable iff (i_srst)
    exec && i_instr == RTBX_OP_INY |=> o_yreg == $past(o_yreg) + 4'h1 && o_skip == (o_yreg == 4'h0))
    else $error("increment y or skip wrong");
  AST_DEY: assert property (@(posedge i_clk) disable iff (i_srst)
    exec && i_instr == RTBX_OP_DEY |=> o_yreg == $past(o_yreg) - 4'h1 && o_skip == (o_yreg == 4'hf))
    else $error("decrement y or skip wrong");
  AST_TMA: assert property (@(posedge i_clk) disable iff (i_srst)
    exec && op_hi == RTBX_OP_TMA_HI |=> o_ram_we && o_ram_wdata == $past(o_acc) && o_xreg == ($past(o_xreg) ^ $past(j_imm)))
    else $error("store to ram wrong");
  AST_SKIPONE: assert property (@(posedge i_clk) disable iff (i_srst)
    o_skip && i_valid |=> !o_skip && !o_ram_we && !o_jump)
    else $error("skipped instruction had effect");
  AST_CALL2: assert property (@(posedge i_clk) disable iff (i_srst)
    i_valid && !st.skip && i_br_kind == RTBX_CL_P2 |=> o_call && o_target[12:7] == RTBX_CALL_PAGE)
    else $error("page two call wrong");

  COV_SWAP_SKIP: cover property (@(posedge i_clk) exec && op_hi == RTBX_OP_SWAP_INC_SKIP_HI ##1 o_skip);
  COV_LXY_RUN: cover property (@(posedge i_clk) i_valid && is_lxy ##1 i_valid && is_lxy);
  COV_IND_JUMP: cover property (@(posedge i_clk) i_valid && i_br_kind == RTBX_BR_IND ##1 o_jump);
endmodule

// file: pkg/rtbx_pkg.sv
// constants for the transfer, ram and branch execution block
// assumes one instruction word per clock from the fetch side
package rtbx_pkg;
  localparam int RTBX_IW = 10;
  localparam logic [9:0] RTBX_OP_TAB = 10'h01e;
  localparam logic [9:0] RTBX_OP_TBA = 10'h00e;
  localparam logic [9:0] RTBX_OP_TAY = 10'h01f;
  localparam logic [9:0] RTBX_OP_TYA = 10'h00c;
  localparam logic [9:0] RTBX_OP_WRITE_WIDE_REG = 10'h01a;
  localparam logic [9:0] RTBX_OP_READ_WIDE_REG = 10'h02a;
  localparam logic [9:0] RTBX_OP_TDA = 10'h029;
  localparam logic [9:0] RTBX_OP_TAD = 10'h051;
  localparam logic [9:0] RTBX_OP_TAZ = 10'h053;
  localparam logic [9:0] RTBX_OP_TAX = 10'h052;
  localparam logic [9:0] RTBX_OP_READ_STACK_PTR = 10'h050;
  localparam logic [9:0] RTBX_OP_INY = 10'h013;
  localparam logic [9:0] RTBX_OP_DEY = 10'h017;
  localparam logic [7:0] RTBX_OP_LZ_HI = 8'h12;
  localparam logic [3:0] RTBX_OP_LXY_HI = 4'h3;
  localparam logic [5:0] RTBX_OP_TAM_HI = 6'h2c;
  localparam logic [5:0] RTBX_OP_XAM_HI = 6'h2d;
  localparam logic [5:0] RTBX_OP_SWAP_DEC_SKIP_HI = 6'h2f;
  localparam logic [5:0] RTBX_OP_SWAP_INC_SKIP_HI = 6'h2e;
  localparam logic [5:0] RTBX_OP_TMA_HI = 6'h2b;
  localparam logic [5:0] RTBX_CALL_PAGE = 6'h02;
  localparam logic [3:0] RTBX_Y_MAX = 4'hf;
  localparam logic [3:0] RTBX_Y_MIN = 4'h0;
  typedef enum logic [2:0]
  {
    RTBX_BR_NONE = 3'b000,
    RTBX_BR_PAGE = 3'b001,
    RTBX_BR_FAR = 3'b010,
    RTBX_BR_IND = 3'b011,
    RTBX_CL_P2 = 3'b100,
    RTBX_CL_FAR = 3'b101,
    RTBX_CL_IND = 3'b110
  } rtbx_br_t;
endpackage

// file: logic/rtbx_target.sv
// branch and call target former
// assumes page and address fields already split by the sequencer
`timescale 1ns/1ps
module rtbx_target
  import rtbx_pkg::*;
(
  input wire rtbx_br_t i_kind,
  input wire logic [5:0] i_cur_page,
  input wire logic [5:0] i_page,
  input wire logic [6:0] i_addr,
  input wire logic [2:0] i_dreg,
  input wire logic [3:0] i_acc,
  output logic [12:0] o_target,
  output logic o_take,
  output logic o_call
);
  always_comb
  begin
    o_target = 13'h0000;
    o_take = 1'b1;
    o_call = 1'b0;
    case (i_kind)
      RTBX_BR_PAGE: o_target = {i_cur_page, i_addr};
      RTBX_BR_FAR: o_target = {i_page, i_addr};
      RTBX_BR_IND: o_target = {i_page, i_dreg, i_acc};
      RTBX_CL_P2:
      begin
        o_target = {RTBX_CALL_PAGE, i_addr};
        o_call = 1'b1;
      end
      RTBX_CL_FAR:
      begin
        o_target = {i_page, i_addr};
        o_call = 1'b1;
      end
      RTBX_CL_IND:
      begin
        o_target = {i_page, i_dreg, i_acc};
        o_call = 1'b1;
      end
      default: o_take = 1'b0;
    endcase
  end
endmodule

// file: tb/rtbx_ram_model.sv
// data ram model on the far side of the execution block
// assumes pointer regs address ram, write lands one edge after the pulse
`timescale 1ns/1ps
module rtbx_ram_model
(
  input wire logic i_clk,
  input wire logic [1:0] i_zreg,
  input wire logic [3:0] i_xreg,
  input wire logic [3:0] i_yreg,
  input wire logic i_we,
  input wire logic [3:0] i_wdata,
  output logic [3:0] o_rdata
);
  logic [3:0] mem [1024];
  logic [9:0] addr_q;
  initial
  begin
    for (int i = 0; i < 1024; i++)
      mem[i] = ~i[3:0];
  end
  assign o_rdata = mem[{i_zreg, i_xreg, i_yreg}];
  // pointer seen at the instruction edge is where the write goes
  always @(posedge i_clk)
  begin
    addr_q <= {i_zreg, i_xreg, i_yreg};
    if (i_we)
      mem[addr_q] <= i_wdata;
  end
endmodule

// file: tb/tb_top.sv
// self-checking bench for the execution block
// assumes the ram model beside it and 40 mhz clock
`timescale 1ns/1ps
module tb_top;
  import rtbx_pkg::*;
  logic i_clk = 0, i_srst = 1, i_valid = 0;
  logic [9:0] i_instr = 0;
  rtbx_br_t i_br_kind = RTBX_BR_NONE;
  logic [5:0] i_br_page = 0, i_cur_page = 0;
  logic [6:0] i_br_addr = 0;
  logic [2:0] i_stack_ptr = 0;
  logic [3:0] i_ram_rdata, o_acc, o_breg, o_xreg, o_yreg, o_ram_wdata;
  logic [1:0] o_zreg;
  logic [2:0] o_dreg;
  logic [7:0] o_ereg;
  logic o_skip, o_ram_we, o_jump, o_call;
  logic [12:0] o_target;
  int failures = 0;
  int check_count = 0;
  always #12.5 i_clk = ~i_clk;
  rtbx_core dut_u (.i_clk(i_clk), .i_srst(i_srst), .i_valid(i_valid), .i_instr(i_instr), .i_br_kind(i_br_kind),
    .i_br_page(i_br_page), .i_br_addr(i_br_addr), .i_cur_page(i_cur_page), .i_stack_ptr(i_stack_ptr),
    .i_ram_rdata(i_ram_rdata), .o_acc(o_acc), .o_breg(o_breg), .o_xreg(o_xreg), .o_yreg(o_yreg), .o_zreg(o_zreg),
    .o_dreg(o_dreg), .o_ereg(o_ereg), .o_skip(o_skip), .o_ram_we(o_ram_we), .o_ram_wdata(o_ram_wdata),
    .o_jump(o_jump), .o_call(o_call), .o_target(o_target));
  rtbx_ram_model ram_u (.i_clk(i_clk), .i_zreg(o_zreg), .i_xreg(o_xreg), .i_yreg(o_yreg), .i_we(o_ram_we),
    .i_wdata(o_ram_wdata), .o_rdata(i_ram_rdata));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [12:0] exp, input logic [12:0] got);
    check_count++;
    if (got !== exp)
    begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic run(input logic [9:0] ins);
    @(posedge i_clk);
    i_valid <= 1'b1;
    i_instr <= ins;
  endtask
  task automatic idle();
    @(posedge i_clk);
    i_valid <= 1'b0;
    i_br_kind <= RTBX_BR_NONE;
    #1;
  endtask
  task automatic setacc(input logic [3:0] v);
    // plain word first ends any pointer-load run and takes a pending skip
    run(10'h000);
    run({2'b11, 4'h0, v});
    run(RTBX_OP_TAY);
    idle();
  endtask
  task automatic test_done();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic test_xfer();
    setacc(4'ha);
    run(RTBX_OP_TBA);
    idle();
    chk("breg", 4'ha, o_breg);
    setacc(4'h5);
    chk("acc row", 4'h5, o_acc);
    run(RTBX_OP_WRITE_WIDE_REG);
    idle();
    chk("ereg", 8'ha5, o_ereg);
    setacc(4'h3);
    run(RTBX_OP_TBA);
    run(RTBX_OP_READ_WIDE_REG);
    idle();
    chk("breg wide", 4'ha, o_breg);
    chk("acc wide", 4'h5, o_acc);
    run(RTBX_OP_TAB);
    idle();
    chk("acc b", 4'ha, o_acc);
    chk("breg kept", 4'ha, o_breg);
    $display("test xfer done");
  endtask
  task automatic test_low();
    setacc(4'hd);
    run(RTBX_OP_TDA);
    idle();
    chk("dreg", 3'h5, o_dreg);
    setacc(4'hf);
    run(RTBX_OP_TAD);
    idle();
    chk("acc d", 4'h5, o_acc);
    setacc(4'hf);
    run({RTBX_OP_LZ_HI, 2'b11});
    run(RTBX_OP_TAZ);
    idle();
    chk("zreg", 2'h3, o_zreg);
    chk("acc z", 4'h3, o_acc);
    setacc(4'hf);
    i_stack_ptr <= 3'h6;
    run(RTBX_OP_READ_STACK_PTR);
    idle();
    chk("acc sp", 4'h6, o_acc);
    $display("test low done");
  endtask
  task automatic test_ptr();
    run({2'b11, 4'h1, 4'h2});
    run({2'b11, 4'h3, 4'h4});
    idle();
    chk("x run", 4'h1, o_xreg);
    chk("y run", 4'h2, o_yreg);
    run(RTBX_OP_TAY);
    run({2'b11, 4'hf, 4'h0});
    idle();
    chk("x imm", 4'hf, o_xreg);
    chk("y imm", 4'h0, o_yreg);
    setacc(4'hf);
    run(RTBX_OP_INY);
    idle();
    chk("y inc", 4'h0, o_yreg);
    chk("skip inc", 1'b1, o_skip);
    run(RTBX_OP_TAY);
    idle();
    chk("acc skipped", 4'hf, o_acc);
    chk("skip clr", 1'b0, o_skip);
    run(RTBX_OP_DEY);
    run(RTBX_OP_TAB);
    idle();
    chk("y dec", 4'hf, o_yreg);
    chk("acc skipped2", 4'hf, o_acc);
    run(RTBX_OP_DEY);
    run(RTBX_OP_INY);
    idle();
    chk("y no skip", 4'hf, o_yreg);
    chk("skip none", 1'b0, o_skip);
    $display("test ptr done");
  endtask
  task automatic test_ram();
    setacc(4'h7);
    run({RTBX_OP_TMA_HI, 4'h5});
    idle();
    chk("we store", 1'b1, o_ram_we);
    chk("wdata store", 4'h7, o_ram_wdata);
    chk("x store", 4'h5, o_xreg);
    idle();
    chk("we pulse", 1'b0, o_ram_we);
    chk("mem store", 4'h7, ram_u.mem[10'h307]);
    run({RTBX_OP_TAM_HI, 4'h5});
    idle();
    chk("acc load", 4'h8, o_acc);
    chk("x load", 4'h0, o_xreg);
    run({RTBX_OP_XAM_HI, 4'h0});
    idle();
    chk("acc swap", 4'h7, o_acc);
    chk("wdata swap", 4'h8, o_ram_wdata);
    idle();
    chk("mem swap", 4'h8, ram_u.mem[10'h307]);
    run({2'b11, 4'h0, 4'hf});
    run({RTBX_OP_SWAP_INC_SKIP_HI, 4'h1});
    run(RTBX_OP_TAB);
    idle();
    chk("acc swapi", 4'h0, o_acc);
    chk("x swapi", 4'h1, o_xreg);
    chk("y swapi", 4'h0, o_yreg);
    chk("mem swapi", 4'h7, ram_u.mem[10'h30f]);
    run({RTBX_OP_SWAP_DEC_SKIP_HI, 4'h1});
    idle();
    chk("acc swapd", 4'hf, o_acc);
    chk("y swapd", 4'hf, o_yreg);
    chk("skip swapd", 1'b1, o_skip);
    run(RTBX_OP_TAY);
    idle();
    chk("acc skipped3", 4'hf, o_acc);
    chk("mem swapd", 4'h0, ram_u.mem[10'h310]);
    $display("test ram done");
  endtask
  task automatic test_branch();
    logic [12:0] exp;
    i_cur_page <= 6'h11;
    i_br_page <= 6'h2a;
    i_br_addr <= 7'h33;
    for (int k = 1; k < 7; k++)
    begin
      @(posedge i_clk);
      i_valid <= 1'b1;
      i_instr <= 10'h000;
      i_br_kind <= rtbx_br_t'(k);
      idle();
      exp = (k == 1) ? {6'h11, 7'h33} : (k == 4) ? {RTBX_CALL_PAGE, 7'h33} : {6'h2a, 7'h33};
      if (k == 3 || k == 6)
        exp = {6'h2a, 3'h5, 4'hf};
      chk("target", exp, o_target);
      chk("call", k > 3, o_call);
      if (k < 4)
        chk("jump", 1'b1, o_jump);
    end
    idle();
    chk("call pulse", 1'b0, o_call);
    $display("test branch done");
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #100000;
    failures++;
    test_done();
  end
  initial
  begin
    repeat (10) @(posedge i_clk);
    i_srst <= 1'b0;
    idle();
    chk("acc rst", 4'h0, o_acc);
    test_xfer();
    test_low();
    test_ptr();
    test_ram();
    test_branch();
    test_done();
  end
endmodule
